// *** hdl/hu_pkg.sv ***
/*
 * Shared constants, types and the bit-rate step function for both ends of the
 * two-wire serial host port.
 * Assumes a single 10 MHz clock on each end and pins already synchronous to it.
 */
`default_nettype none
package hu_pkg;
    // ==========================================================================
    // Clock and reset timing
    // ==========================================================================
    localparam int unsigned HU_CLK_PERIOD_NS = 100;
    localparam int unsigned HU_RST_MIN_NS = 120_000;
    localparam int unsigned HU_RST_CYC = (HU_RST_MIN_NS + HU_CLK_PERIOD_NS - 1)
        / HU_CLK_PERIOD_NS;
    localparam logic [10:0] HU_RST_CNT_MAX = 11'(HU_RST_CYC);
    localparam logic [10:0] HU_RST_CNT_ONE = 11'h001;

    // ==========================================================================
    // Bit-rate generator
    // ==========================================================================
    // The accumulator is 19 bits wide because a bit lasts 524288 / field clocks.
    localparam logic [15:0] HU_BAUD_DEFAULT = 16'h004d;
    localparam logic [18:0] HU_ACC_ZERO = 19'h00000;
    localparam logic [18:0] HU_ACC_HALF = 19'h40000;

    // ==========================================================================
    // Character framing
    // ==========================================================================
    localparam logic [2:0] HU_IDX_FIRST = 3'h0;
    localparam logic [2:0] HU_IDX_LAST = 3'h7;
    localparam logic [2:0] HU_IDX_ONE = 3'h1;
    localparam logic HU_LINE_IDLE = 1'b1;
    localparam logic HU_START_LVL = 1'b0;
    localparam logic HU_STOP_LVL = 1'b1;

    typedef enum logic [3:0] {
        HU_IDLE = 4'h1,
        HU_START = 4'h2,
        HU_DATA = 4'h4,
        HU_STOP = 4'h8
    } hu_ser_st_t;

    typedef enum logic [2:0] {
        HU_DEV_HALT = 3'h1,
        HU_DEV_INIT = 3'h2,
        HU_DEV_RUN = 3'h4
    } hu_dev_st_t;

    typedef enum logic [1:0] {
        HU_DO_PULSE = 2'h0,
        HU_DO_IRQ = 2'h1,
        HU_DO_ZC = 2'h2,
        HU_DO_DIR = 2'h3
    } hu_do_sel_t;

    // One clock of the bit-rate accumulator; bit 19 is the bit-time tick.
    function automatic logic [19:0] hu_acc_step(input logic [18:0] acc,
                                               input logic [15:0] baud);
        hu_acc_step = {1'b0, acc} + {4'h0, baud};
    endfunction
endpackage
`default_nettype wire

// *** hdl/hu_link_if.sv ***
/*
 * The two serial wires between the measurement device and its host.
 * Assumes both ends share one clock domain in simulation; no clock travels here.
 */
`default_nettype none
interface hu_link_if;
    logic dev_tx;
    logic host_tx;
    modport dev (output dev_tx, input host_tx);
    modport host (input dev_tx, output host_tx);
endinterface
`default_nettype wire

// *** hdl/hu_dev_end.sv ***
/*
 * Device end of the serial host port: transmitter, receiver, bit-rate field,
 * filtered chip reset with its initialization step, and the digital output mux.
 * Assumes the host end drives link.host_tx and keeps to the programmed rate.
 */
`default_nettype none
module hu_dev_end (
    input wire logic i_mclk,
    input wire logic i_rstn,
    hu_link_if.dev link,
    input wire logic i_chip_reset_n,
    input wire logic i_baud_we,
    input wire logic [15:0] i_baud_value,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    input wire hu_pkg::hu_do_sel_t i_do_sel,
    input wire logic i_energy_pulse,
    input wire logic i_irq_flag,
    input wire logic i_zero_cross,
    input wire logic i_energy_dir,
    output logic o_tx_ready,
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_rx_frame_err,
    output logic o_dout,
    output logic o_running,
    output logic [15:0] o_baud_field
);
    import hu_pkg::*;
    // ==========================================================================
    // Reset filter, initialization, bit-rate field and digital output
    // ==========================================================================
    logic [10:0] rst_cnt, next_rst_cnt;
    hu_dev_st_t dev_st, next_dev_st;
    logic [15:0] baud_field, next_baud_field;
    logic dout, next_dout, running, run;
    always_comb begin
        next_rst_cnt = rst_cnt;
        next_dev_st = dev_st;
        next_baud_field = baud_field;
        next_dout = 1'b0;
        if (i_chip_reset_n) begin
            next_rst_cnt = '0;
        end else if (rst_cnt != HU_RST_CNT_MAX) begin
            next_rst_cnt = rst_cnt + HU_RST_CNT_ONE;
        end
        unique case (dev_st)
            HU_DEV_HALT: begin
                if (i_chip_reset_n) begin
                    next_dev_st = HU_DEV_INIT;
                end
            end
            HU_DEV_INIT: begin
                next_baud_field = HU_BAUD_DEFAULT;
                next_dev_st = HU_DEV_RUN;
            end
            HU_DEV_RUN: begin
                if (i_baud_we) begin
                    next_baud_field = i_baud_value;
                end
            end
        endcase
        if (run) begin
            unique case (i_do_sel)
                HU_DO_PULSE: next_dout = i_energy_pulse;
                HU_DO_IRQ: next_dout = i_irq_flag;
                HU_DO_ZC: next_dout = i_zero_cross;
                HU_DO_DIR: next_dout = i_energy_dir;
            endcase
        end
        // Held low for more than the minimum: stop everything.
        if (!i_chip_reset_n && rst_cnt == HU_RST_CNT_MAX) begin
            next_dev_st = HU_DEV_HALT;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            rst_cnt <= '0;
            dev_st <= HU_DEV_INIT;
            baud_field <= HU_BAUD_DEFAULT;
            dout <= 1'b0;
            running <= 1'b0;
        end else begin
            rst_cnt <= next_rst_cnt;
            dev_st <= next_dev_st;
            baud_field <= next_baud_field;
            dout <= next_dout;
            running <= run;
        end
    end
    assign run = (dev_st == HU_DEV_RUN);
    // ==========================================================================
    // Transmitter
    // ==========================================================================
    hu_ser_st_t tx_st, next_tx_st;
    logic [18:0] tx_acc, next_tx_acc;
    logic [7:0] tx_shift, next_tx_shift;
    logic [2:0] tx_idx, next_tx_idx;
    logic tx_line, next_tx_line, tx_ready, next_tx_ready, tx_tick;
    logic [19:0] tx_step;
    always_comb begin
        tx_step = hu_acc_step(tx_acc, baud_field);
        tx_tick = tx_step[19];
        next_tx_st = tx_st;
        next_tx_acc = tx_step[18:0];
        next_tx_shift = tx_shift;
        next_tx_idx = tx_idx;
        next_tx_line = tx_line;
        next_tx_ready = tx_ready;
        unique case (tx_st)
            HU_IDLE: begin
                next_tx_acc = HU_ACC_ZERO;
                next_tx_ready = 1'b1;
                if (i_tx_valid && tx_ready) begin
                    next_tx_shift = i_tx_data;
                    next_tx_line = HU_START_LVL;
                    next_tx_ready = 1'b0;
                    next_tx_st = HU_START;
                end
            end
            HU_START: begin
                if (tx_tick) begin
                    next_tx_line = tx_shift[0];
                    next_tx_idx = HU_IDX_FIRST;
                    next_tx_st = HU_DATA;
                end
            end
            HU_DATA: begin
                if (tx_tick) begin
                    if (tx_idx == HU_IDX_LAST) begin
                        next_tx_line = HU_STOP_LVL;
                        next_tx_st = HU_STOP;
                    end else begin
                        next_tx_shift = tx_shift >> 1;
                        next_tx_line = tx_shift[1];
                        next_tx_idx = tx_idx + HU_IDX_ONE;
                    end
                end
            end
            HU_STOP: begin
                if (tx_tick) begin
                    next_tx_st = HU_IDLE;
                end
            end
        endcase
        if (!run) begin
            next_tx_st = HU_IDLE;
            next_tx_acc = HU_ACC_ZERO;
            next_tx_line = HU_LINE_IDLE;
            next_tx_ready = 1'b0;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            tx_st <= HU_IDLE;
            tx_acc <= HU_ACC_ZERO;
            tx_shift <= '0;
            tx_idx <= HU_IDX_FIRST;
            tx_line <= HU_LINE_IDLE;
            tx_ready <= 1'b0;
        end else begin
            tx_st <= next_tx_st;
            tx_acc <= next_tx_acc;
            tx_shift <= next_tx_shift;
            tx_idx <= next_tx_idx;
            tx_line <= next_tx_line;
            tx_ready <= next_tx_ready;
        end
    end
    assign link.dev_tx = tx_line;
    assign o_tx_ready = tx_ready;
    // ==========================================================================
    // Receiver
    // ==========================================================================
    // Its own accumulator lets it run while the transmitter is busy.
    hu_ser_st_t rx_st, next_rx_st;
    logic [18:0] rx_acc, next_rx_acc;
    logic [7:0] rx_shift, next_rx_shift;
    logic [2:0] rx_idx, next_rx_idx;
    logic rx_q, rx_prev, rx_valid, next_rx_valid, rx_err, next_rx_err, rx_tick;
    logic [7:0] rx_data, next_rx_data;
    logic [19:0] rx_step;
    always_comb begin
        rx_step = hu_acc_step(rx_acc, baud_field);
        rx_tick = rx_step[19];
        next_rx_st = rx_st;
        next_rx_acc = rx_step[18:0];
        next_rx_shift = rx_shift;
        next_rx_idx = rx_idx;
        next_rx_data = rx_data;
        next_rx_valid = 1'b0;
        next_rx_err = 1'b0;
        unique case (rx_st)
            HU_IDLE: begin
                // Preloading half a bit puts every tick at a bit centre.
                next_rx_acc = HU_ACC_HALF;
                if (rx_prev == HU_LINE_IDLE && rx_q == HU_START_LVL) begin
                    next_rx_st = HU_START;
                end
            end
            HU_START: begin
                if (rx_tick) begin
                    next_rx_idx = HU_IDX_FIRST;
                    next_rx_st = (rx_q == HU_START_LVL) ? HU_DATA : HU_IDLE;
                end
            end
            HU_DATA: begin
                if (rx_tick) begin
                    next_rx_shift = {rx_q, rx_shift[7:1]};
                    if (rx_idx == HU_IDX_LAST) begin
                        next_rx_st = HU_STOP;
                    end else begin
                        next_rx_idx = rx_idx + HU_IDX_ONE;
                    end
                end
            end
            HU_STOP: begin
                if (rx_tick) begin
                    next_rx_st = HU_IDLE;
                    next_rx_data = rx_shift;
                    next_rx_valid = (rx_q == HU_STOP_LVL);
                    next_rx_err = (rx_q != HU_STOP_LVL);
                end
            end
        endcase
        if (!run) begin
            next_rx_st = HU_IDLE;
            next_rx_acc = HU_ACC_HALF;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            rx_st <= HU_IDLE;
            rx_acc <= HU_ACC_HALF;
            rx_shift <= '0;
            rx_idx <= HU_IDX_FIRST;
            rx_q <= HU_LINE_IDLE;
            rx_prev <= HU_LINE_IDLE;
            rx_data <= '0;
            rx_valid <= 1'b0;
            rx_err <= 1'b0;
        end else begin
            rx_st <= next_rx_st;
            rx_acc <= next_rx_acc;
            rx_shift <= next_rx_shift;
            rx_idx <= next_rx_idx;
            rx_q <= link.host_tx;
            rx_prev <= rx_q;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
            rx_err <= next_rx_err;
        end
    end
    assign o_rx_data = rx_data;
    assign o_rx_valid = rx_valid;
    assign o_rx_frame_err = rx_err;
    assign o_dout = dout;
    assign o_running = running;
    assign o_baud_field = baud_field;
endmodule
`default_nettype wire

// *** hdl/hu_host_end.sv ***
/*
 * Host end of the serial port: an independent transmitter and receiver whose
 * bit rate comes from a field computed with the same formula as the device's.
 * Assumes the device end drives link.dev_tx; the host owns link.host_tx.
 */
`default_nettype none
module hu_host_end (
    input wire logic i_mclk,
    input wire logic i_rstn,
    hu_link_if.host link,
    input wire logic [15:0] i_baud,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_rx_frame_err
);
    import hu_pkg::*;

    // ==========================================================================
    // Transmitter
    // ==========================================================================
    // The caller must keep i_baud at or below the device's top rate.
    hu_ser_st_t tx_st, next_tx_st;
    logic [18:0] tx_acc, next_tx_acc;
    logic [7:0] tx_shift, next_tx_shift;
    logic [2:0] tx_idx, next_tx_idx;
    logic tx_line, next_tx_line;
    logic tx_ready, next_tx_ready;
    logic [19:0] tx_step;

    always_comb begin
        tx_step = hu_acc_step(tx_acc, i_baud);
        next_tx_st = tx_st;
        next_tx_acc = tx_step[18:0];
        next_tx_shift = tx_shift;
        next_tx_idx = tx_idx;
        next_tx_line = tx_line;
        next_tx_ready = tx_ready;
        unique case (tx_st)
            HU_IDLE: begin
                next_tx_acc = HU_ACC_ZERO;
                next_tx_ready = 1'b1;
                if (i_tx_valid && tx_ready) begin
                    next_tx_shift = i_tx_data;
                    next_tx_line = HU_START_LVL;
                    next_tx_ready = 1'b0;
                    next_tx_st = HU_START;
                end
            end
            HU_START: begin
                if (tx_step[19]) begin
                    next_tx_line = tx_shift[0];
                    next_tx_idx = HU_IDX_FIRST;
                    next_tx_st = HU_DATA;
                end
            end
            HU_DATA: begin
                if (tx_step[19]) begin
                    if (tx_idx == HU_IDX_LAST) begin
                        next_tx_line = HU_STOP_LVL;
                        next_tx_st = HU_STOP;
                    end else begin
                        next_tx_shift = tx_shift >> 1;
                        next_tx_line = tx_shift[1];
                        next_tx_idx = tx_idx + HU_IDX_ONE;
                    end
                end
            end
            HU_STOP: begin
                if (tx_step[19]) begin
                    next_tx_st = HU_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            tx_st <= HU_IDLE;
            tx_acc <= HU_ACC_ZERO;
            tx_shift <= '0;
            tx_idx <= HU_IDX_FIRST;
            tx_line <= HU_LINE_IDLE;
            tx_ready <= 1'b0;
        end else begin
            tx_st <= next_tx_st;
            tx_acc <= next_tx_acc;
            tx_shift <= next_tx_shift;
            tx_idx <= next_tx_idx;
            tx_line <= next_tx_line;
            tx_ready <= next_tx_ready;
        end
    end

    assign link.host_tx = tx_line;
    assign o_tx_ready = tx_ready;

    // ==========================================================================
    // Receiver
    // ==========================================================================
    hu_ser_st_t rx_st, next_rx_st;
    logic [18:0] rx_acc, next_rx_acc;
    logic [7:0] rx_shift, next_rx_shift;
    logic [2:0] rx_idx, next_rx_idx;
    logic rx_q, rx_prev;
    logic [7:0] rx_data, next_rx_data;
    logic rx_valid, next_rx_valid;
    logic rx_err, next_rx_err;
    logic [19:0] rx_step;

    always_comb begin
        rx_step = hu_acc_step(rx_acc, i_baud);
        next_rx_st = rx_st;
        next_rx_acc = rx_step[18:0];
        next_rx_shift = rx_shift;
        next_rx_idx = rx_idx;
        next_rx_data = rx_data;
        next_rx_valid = 1'b0;
        next_rx_err = 1'b0;
        unique case (rx_st)
            HU_IDLE: begin
                next_rx_acc = HU_ACC_HALF;
                if (rx_prev == HU_LINE_IDLE && rx_q == HU_START_LVL) begin
                    next_rx_st = HU_START;
                end
            end
            HU_START: begin
                if (rx_step[19]) begin
                    next_rx_idx = HU_IDX_FIRST;
                    next_rx_st = (rx_q == HU_START_LVL) ? HU_DATA : HU_IDLE;
                end
            end
            HU_DATA: begin
                if (rx_step[19]) begin
                    next_rx_shift = {rx_q, rx_shift[7:1]};
                    if (rx_idx == HU_IDX_LAST) begin
                        next_rx_st = HU_STOP;
                    end else begin
                        next_rx_idx = rx_idx + HU_IDX_ONE;
                    end
                end
            end
            HU_STOP: begin
                if (rx_step[19]) begin
                    next_rx_st = HU_IDLE;
                    next_rx_data = rx_shift;
                    next_rx_valid = (rx_q == HU_STOP_LVL);
                    next_rx_err = (rx_q != HU_STOP_LVL);
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            rx_st <= HU_IDLE;
            rx_acc <= HU_ACC_HALF;
            rx_shift <= '0;
            rx_idx <= HU_IDX_FIRST;
            rx_q <= HU_LINE_IDLE;
            rx_prev <= HU_LINE_IDLE;
            rx_data <= '0;
            rx_valid <= 1'b0;
            rx_err <= 1'b0;
        end else begin
            rx_st <= next_rx_st;
            rx_acc <= next_rx_acc;
            rx_shift <= next_rx_shift;
            rx_idx <= next_rx_idx;
            rx_q <= link.dev_tx;
            rx_prev <= rx_q;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
            rx_err <= next_rx_err;
        end
    end

    assign o_rx_data = rx_data;
    assign o_rx_valid = rx_valid;
    assign o_rx_frame_err = rx_err;
endmodule
`default_nettype wire

// *** verif/hu_link_assertions.sv ***
/*
 * Concurrent checks on the serial wires and the device end's user side.
 * Assumes one clock and a synchronous active-low reset shared by both ends.
 */
`default_nettype none
module hu_link_assertions (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic dev_tx,
    input wire logic host_tx,
    input wire logic i_chip_reset_n,
    input wire logic i_tx_valid,
    input wire logic i_baud_we,
    input wire logic [15:0] i_baud_value,
    input wire logic o_tx_ready,
    input wire logic o_rx_valid,
    input wire logic o_rx_frame_err,
    input wire logic o_running,
    input wire logic o_dout,
    input wire logic [15:0] o_baud_field
);
    import hu_pkg::*;
    // ==========================================================================
    // Low-time counter of the chip reset pin
    // ==========================================================================
    logic [10:0] low_cnt;
    logic [10:0] next_low_cnt;
    always_comb begin
        next_low_cnt = i_chip_reset_n ? 11'h000 : low_cnt + {10'h000, low_cnt != 11'h7ff};
    end
    always_ff @(posedge i_mclk) begin
        low_cnt <= i_rstn ? next_low_cnt : 11'h000;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // ==========================================================================
    // Properties
    // ==========================================================================
    lines_idle_a: assert property ($rose(i_rstn) |-> dev_tx && host_tx)
        else $error("lines not idle after reset");
    start_bit_a: assert property (i_tx_valid && o_tx_ready |=> !o_tx_ready && !dev_tx)
        else $error("no start bit after accept");
    ready_idle_a: assert property (o_tx_ready |-> dev_tx)
        else $error("line low while idle");
    baud_write_a: assert property (i_baud_we && o_running
        |=> o_baud_field == $past(i_baud_value))
        else $error("field not written");
    rx_excl_a: assert property (!(o_rx_valid && o_rx_frame_err))
        else $error("valid and error together");
    rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid)
        else $error("receive pulse too long");
    short_low_a: assert property (low_cnt != 11'h000 && low_cnt <= HU_RST_CNT_MAX
        |-> o_running)
        else $error("short reset pulse acted");
    long_halt_a: assert property (low_cnt == HU_RST_CNT_MAX + 11'h002
        |-> ##[0:2] !o_running)
        else $error("long reset did not halt");
    init_load_a: assert property ($rose(o_running) |-> o_baud_field == 16'h004d)
        else $error("field not reloaded");
    dout_off_a: assert property (!o_running |-> !o_dout)
        else $error("output active when halted");
    accept_c: cover property (i_tx_valid && o_tx_ready);
    rx_c: cover property (o_rx_valid);
    halt_c: cover property ($fell(o_running));
endmodule
`default_nettype wire

// *** verif/host_uart_port_with_reset_tb.sv ***
/*
 * Self-checking bench joining device and host ends through one link.
 * Assumes the design's 10 MHz clock and the 524288-based bit-rate field.
 */
`default_nettype none
module host_uart_port_with_reset_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import hu_pkg::*;
    // A field of 0x2000 gives exactly 64 clocks a bit, keeping frames short.
    localparam logic [15:0] FAST = 16'h2000;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_chip_reset_n = 1'b1;
    logic i_baud_we = 1'b0;
    logic [15:0] i_baud_value = 16'h0000;
    logic [15:0] h_baud = 16'h004d;
    logic [7:0] i_tx_data = 8'h00;
    logic [7:0] h_tx_data = 8'h00;
    logic i_tx_valid = 1'b0;
    logic h_tx_valid = 1'b0;
    hu_do_sel_t i_do_sel = HU_DO_PULSE;
    logic [3:0] srcs = 4'h0;
    logic o_tx_ready, o_rx_valid, o_rx_frame_err, o_dout, o_running;
    logic h_tx_ready, h_rx_valid, h_rx_frame_err;
    logic [7:0] o_rx_data, h_rx_data;
    logic [15:0] o_baud_field;
    logic [7:0] dev_q[$];
    logic [7:0] host_q[$];
    int mismatches = 0;
    int check_count = 0;
    int errs = 0;
    hu_link_if i_hu_link_if ();
    hu_dev_end i_hu_dev_end (.i_mclk(i_mclk), .i_rstn(i_rstn), .link(i_hu_link_if.dev),
        .i_chip_reset_n(i_chip_reset_n), .i_baud_we(i_baud_we), .i_baud_value(i_baud_value),
        .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .i_do_sel(i_do_sel),
        .i_energy_pulse(srcs[0]), .i_irq_flag(srcs[1]), .i_zero_cross(srcs[2]),
        .i_energy_dir(srcs[3]), .o_tx_ready(o_tx_ready), .o_rx_data(o_rx_data),
        .o_rx_valid(o_rx_valid), .o_rx_frame_err(o_rx_frame_err), .o_dout(o_dout),
        .o_running(o_running), .o_baud_field(o_baud_field));
    hu_host_end i_hu_host_end (.i_mclk(i_mclk), .i_rstn(i_rstn), .link(i_hu_link_if.host),
        .i_baud(h_baud), .i_tx_data(h_tx_data), .i_tx_valid(h_tx_valid),
        .o_tx_ready(h_tx_ready), .o_rx_data(h_rx_data), .o_rx_valid(h_rx_valid),
        .o_rx_frame_err(h_rx_frame_err));
    hu_link_assertions i_hu_link_assertions (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .dev_tx(i_hu_link_if.dev_tx), .host_tx(i_hu_link_if.host_tx),
        .i_chip_reset_n(i_chip_reset_n), .i_tx_valid(i_tx_valid), .i_baud_we(i_baud_we),
        .i_baud_value(i_baud_value), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
        .o_rx_frame_err(o_rx_frame_err), .o_running(o_running), .o_dout(o_dout),
        .o_baud_field(o_baud_field));
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        if (o_rx_valid === 1'b1) dev_q.push_back(o_rx_data);
        if (h_rx_valid === 1'b1) host_q.push_back(h_rx_data);
        if (i_rstn && (o_rx_frame_err !== 1'b0 || h_rx_frame_err !== 1'b0)) errs++;
    end
    // ==========================================================================
    // Tasks
    // ==========================================================================
    task automatic step(input int c);
        repeat (c) @(posedge i_mclk);
        #10;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic timeout();
        mismatches++;
        $display("[FAIL] %0t: wait ran out", $time);
        results();
    endtask
    // Holds the byte until ready is seen high across an edge, then releases it.
    task automatic offer(input logic host, input logic [7:0] b);
        int k;
        k = 0;
        step(1);
        if (host) {h_tx_data, h_tx_valid} = {b, 1'b1};
        else {i_tx_data, i_tx_valid} = {b, 1'b1};
        while ((host ? h_tx_ready : o_tx_ready) !== 1'b1 && k < 3000) begin
            step(1);
            k++;
        end
        if (k == 3000) timeout();
        step(1);
        if (host) h_tx_valid = 1'b0;
        else i_tx_valid = 1'b0;
    endtask
    task automatic wire_chk(input logic [7:0] b);
        int k;
        k = 0;
        while (i_hu_link_if.dev_tx !== 1'b0 && k < 3000) begin
            step(1);
            k++;
        end
        if (k == 3000) timeout();
        step(32);
        check({15'h0000, i_hu_link_if.dev_tx}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            step(64);
            check({15'h0000, i_hu_link_if.dev_tx}, {15'h0000, b[i]});
        end
        step(64);
        check({15'h0000, i_hu_link_if.dev_tx}, 16'h0001);
    endtask
    task automatic wait_q(input int nd, input int nh);
        int k;
        k = 0;
        while ((dev_q.size() < nd || host_q.size() < nh) && k < 3000) begin
            step(1);
            k++;
        end
        if (k == 3000) timeout();
    endtask
    // ==========================================================================
    // Main sequence
    // ==========================================================================
    initial begin
        step(8);
        i_rstn = 1'b1;
        step(3);
        check(o_baud_field, 16'h004d);
        check({15'h0000, i_hu_link_if.host_tx}, 16'h0001);
        check({15'h0000, o_running}, 16'h0001);
        $display("test reset done");
        {i_baud_value, i_baud_we, h_baud} = {FAST, 1'b1, FAST};
        step(1);
        i_baud_we = 1'b0;
        step(1);
        check(o_baud_field, FAST);
        fork
            offer(1'b0, 8'ha5);
            offer(1'b1, 8'h3c);
            wire_chk(8'ha5);
        join
        wait_q(1, 1);
        check({8'h00, host_q[0]}, 16'h00a5);
        check({8'h00, dev_q[0]}, 16'h003c);
        $display("test duplex done");
        offer(1'b1, 8'h00);
        offer(1'b1, 8'hff);
        wait_q(3, 1);
        check({8'h00, dev_q[1]}, 16'h0000);
        check({8'h00, dev_q[2]}, 16'h00ff);
        check(16'(errs), 16'h0000);
        $display("test back to back done");
        for (int s = 0; s < 4; s++) begin
            i_do_sel = hu_do_sel_t'(s);
            srcs = 4'h1 << s;
            step(2);
            check({15'h0000, o_dout}, 16'h0001);
            srcs = ~srcs;
            step(2);
            check({15'h0000, o_dout}, 16'h0000);
        end
        $display("test output select done");
        i_chip_reset_n = 1'b0;
        step(1200);
        i_chip_reset_n = 1'b1;
        step(3);
        check({15'h0000, o_running}, 16'h0001);
        i_chip_reset_n = 1'b0;
        step(1300);
        check({14'h0000, o_running, o_tx_ready}, 16'h0000);
        i_chip_reset_n = 1'b1;
        step(3);
        check({15'h0000, o_running}, 16'h0001);
        check(o_baud_field, 16'h004d);
        $display("test chip reset done");
        results();
    end
endmodule
`default_nettype wire
